/* File: rtl/drsp_core.v */
// Hand/auto reference selection, ramp, limits and PI process controller
//
// Contract
// RULE1: Open loop: ramp then speed limit reference
// RULE2: Output clamped to maximum output frequency
// RULE3: Closed loop: speed driven by PID controller
// RULE4: Keys act only when individually enabled; key_up and key_down have no enable and act in hand mode
// RULE5: Hand key: hand mode, local reference
// RULE6: Auto key: auto mode, remote reference, remote control
// RULE7: Site Local: local reference always active
// RULE8: Site Remote: remote reference always active
// RULE9: Linked site follows last hand/auto mode
// RULE10: Exactly one reference active at once
// RULE11: Local reference kept across power-down
// RULE12: Loop mode applies only with remote reference
// RULE13: Closed loop reduces feedback-setpoint error
// RULE14: Normal lowers, inverse raises speed on excess
// RULE15: Proportional term scaled by configured gain
// RULE16: Integrate error; maximum integral time disables it
// RULE17: Selectable feedback source, analog 54 default
// RULE18: Fixed update interval, output within speed limits
`timescale 1ns/1ps
`include "drsp_map.vh"
module drsp_core #(
	parameter PID_CYCLES = `DRSP_PID_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Operator keypad keys, pulses from the keypad logic
	input wire key_hand,
	input wire key_off,
	input wire key_auto,
	input wire key_reset,
	input wire key_up,
	input wire key_down,
	// Key enables
	input wire en_hand,
	input wire en_off,
	input wire en_auto,
	input wire en_reset,
	// Remote commands from digital inputs or serial link
	input wire remote_start,
	input wire remote_stop,
	input wire [15:0] remote_ref,
	// Retained local reference, from nonvolatile store
	input wire [15:0] local_ref_saved,
	input wire local_ref_load,
	// Configuration
	input wire [1:0] cfg_mode,
	input wire [1:0] ref_site,
	input wire pid_inverse,
	input wire [15:0] pid_kp,
	input wire [13:0] pid_ti,
	input wire [1:0] fb_select,
	input wire [15:0] speed_min,
	input wire [15:0] speed_max,
	input wire [15:0] freq_max,
	input wire [15:0] ramp_step,
	// Feedback sources
	input wire [15:0] fb_ain54,
	input wire [15:0] fb_ain53,
	input wire [15:0] fb_bus,
	input wire [15:0] fb_aux,
	// Status and outputs
	output reg hand_mode,
	output reg running,
	output reg alarm_clear,
	output wire local_active,
	output reg [15:0] local_ref,
	output reg [15:0] motor_cmd
);
	reg auto_q;
	reg [15:0] ramp_q;
	reg signed [31:0] integ_q;
	reg signed [31:0] pi_q;
	reg [15:0] ti_div_q;
	// Remote command synchroniser stages
	reg [1:0] rcmd_s1_q;
	reg [1:0] rcmd_s2_q;
	reg [1:0] rcmd_s3_q;
	reg [1:0] rcmd_q;
	reg use_local;
	reg [15:0] fb;
	wire tick;
	wire hand_go;
	wire auto_go;
	wire off_go;
	wire closed;
	wire [15:0] target;
	wire signed [16:0] err;
	wire signed [16:0] err_dir;
	wire signed [33:0] p_term;
	wire signed [31:0] pi_sum;
	wire [15:0] pi_speed;

	function [15:0] clamp16;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			if (v < lo)
				clamp16 = lo;
			else if (v > hi)
				clamp16 = hi;
			else
				clamp16 = v;
		end
	endfunction

	function [15:0] sat_u16;
		input signed [31:0] v;
		begin
			if (v < 32'sd0)
				sat_u16 = 16'h0000;
			else if (v > 32'sd65535)
				sat_u16 = 16'hffff;
			else
				sat_u16 = v[15:0];
		end
	endfunction

	// Moves at most one step toward the target per call
	function [15:0] ramp_toward;
		input [15:0] cur;
		input [15:0] tgt;
		input [15:0] step;
		begin
			if (tgt > cur) begin
				if (tgt - cur > step)
					ramp_toward = cur + step;
				else
					ramp_toward = tgt;
			end else if (cur - tgt > step) begin
				ramp_toward = cur - step;
			end else begin
				ramp_toward = tgt;
			end
		end
	endfunction

	drsp_tick #(
		.PERIOD(PID_CYCLES)
	) u_tick (
		.clk(clk),
		.reset(reset),
		.tick(tick)
	);

	// Remote commands come from pins; three stages, second and third must agree
	always @(posedge clk) begin
		if (reset) begin
			rcmd_s1_q <= 2'h0;
			rcmd_s2_q <= 2'h0;
			rcmd_s3_q <= 2'h0;
			rcmd_q <= 2'h0;
		end else begin
			rcmd_s1_q <= {remote_stop, remote_start};
			rcmd_s2_q <= rcmd_s1_q;
			rcmd_s3_q <= rcmd_s2_q;
			// Each bit moves only when both late stages show the new level
			rcmd_q <= (rcmd_s2_q & rcmd_s3_q) | (rcmd_q & (rcmd_s2_q | rcmd_s3_q));
		end
	end

	// Enabled keys; a disabled key is dropped without notice
	assign hand_go = key_hand && en_hand; // RULE4
	assign auto_go = key_auto && en_auto; // RULE4
	assign off_go = key_off && en_off; // RULE4

	// Hand/auto/off keypad handling
	always @(posedge clk) begin
		if (reset) begin
			hand_mode <= 1'b0;
			auto_q <= 1'b0;
			running <= 1'b0;
			alarm_clear <= 1'b0;
		end else begin
			alarm_clear <= key_reset & en_reset; // RULE4
			if (hand_go) begin
				hand_mode <= 1'b1; // RULE5
				auto_q <= 1'b0;
				running <= 1'b1; // RULE4
			end else if (auto_go) begin
				hand_mode <= 1'b0; // RULE6
				auto_q <= 1'b1;
			end else if (off_go) begin
				// Mode memory kept so linked site stays as before off
				running <= 1'b0; // RULE4
			end else if (auto_q && !hand_mode) begin
				if (rcmd_q[0])
					running <= 1'b1; // RULE6
				else if (rcmd_q[1])
					running <= 1'b0; // RULE6
			end
		end
	end

	// Single select bit, so both or neither can never be active
	always @* begin
		use_local = hand_mode; // RULE10
		case (ref_site)
			`DRSP_SITE_LOCAL: begin
				use_local = 1'b1; // RULE7
			end
			`DRSP_SITE_REMOTE: begin
				use_local = 1'b0; // RULE8
			end
			default: begin
				use_local = hand_mode; // RULE9
			end
		endcase
	end
	assign local_active = use_local;

	// Local reference, cleared by reset, restored from the retained copy on local_ref_load
	// Saving the copy to the store lies outside this block
	always @(posedge clk) begin
		if (reset) begin
			local_ref <= `DRSP_LOCAL_RST;
		end else if (local_ref_load) begin
			local_ref <= local_ref_saved; // RULE11
		end else if (hand_mode && key_up && local_ref != 16'hffff) begin
			local_ref <= local_ref + `DRSP_LREF_STEP; // RULE5
		end else if (hand_mode && key_down && local_ref != 16'h0000) begin
			local_ref <= local_ref - `DRSP_LREF_STEP; // RULE5
		end
	end

	// Loop mode matters only on the remote reference
	assign closed = !use_local && (cfg_mode == `DRSP_CFG_CLOSED); // RULE12 RULE3
	assign target = use_local ? local_ref : remote_ref;

	// Feedback source; the first analog input is the default
	always @* begin
		fb = fb_ain54;
		case (fb_select)
			`DRSP_FB_AIN54: begin
				fb = fb_ain54; // RULE17
			end
			`DRSP_FB_AIN53: begin
				fb = fb_ain53;
			end
			`DRSP_FB_BUS: begin
				fb = fb_bus;
			end
			default: begin
				fb = fb_aux;
			end
		endcase
	end

	// Positive error means speed must rise with normal action, fall with inverse
	assign err = {1'b0, target} - {1'b0, fb}; // RULE13
	assign err_dir = (pid_inverse == `DRSP_ACT_INVERSE) ? -err : err; // RULE14
	assign p_term = (err_dir * $signed({1'b0, pid_kp})) >>> 8; // RULE15
	assign pi_sum = p_term[31:0] + integ_q;
	assign pi_speed = sat_u16(pi_q);

	// PI update on the fixed tick; integrator steps once per pid_ti+1 ticks
	always @(posedge clk) begin
		if (reset || !closed || !running) begin
			integ_q <= 32'sd0;
			pi_q <= 32'sd0;
			ti_div_q <= 16'h0000;
		end else if (tick) begin // RULE18
			pi_q <= pi_sum; // RULE3
			// Maximum integral time turns the integrator off
			if (pid_ti >= `DRSP_TI_OFF) begin
				integ_q <= 32'sd0; // RULE16
			end else if (ti_div_q >= {2'b00, pid_ti}) begin
				ti_div_q <= 16'h0000;
				// Clamp guards against windup at the saturation limits
				if (!(pi_speed >= speed_max && err_dir > 0) &&
					!(pi_speed <= speed_min && err_dir < 0))
					integ_q <= integ_q + p_term[31:0]; // RULE16
			end else begin
				ti_div_q <= ti_div_q + 16'h0001;
			end
		end
	end

	// Ramp limiter in open loop only, then speed and frequency limits
	always @(posedge clk) begin
		if (reset) begin
			ramp_q <= 16'h0000;
			motor_cmd <= 16'h0000;
		end else begin
			if (!running) begin
				ramp_q <= 16'h0000;
			end else if (closed) begin
				ramp_q <= clamp16(pi_speed, speed_min, speed_max); // RULE18
			end else begin
				// Open loop: ramp first, speed limits applied below
				// One step per clock, so ramp_step sets the slew per cycle
				ramp_q <= ramp_toward(ramp_q, target, ramp_step); // RULE1
			end
			if (!running)
				motor_cmd <= 16'h0000;
			else
				motor_cmd <= clamp16(clamp16(ramp_q, speed_min, speed_max),
					16'h0000, freq_max); // RULE1 RULE2
		end
	end
endmodule

/* File: pkg/drsp_map.vh */
// Constants for the reference select and process controller
`ifndef DRSP_MAP_VH
`define DRSP_MAP_VH
`define DRSP_CFG_OPEN 2'h0
`define DRSP_CFG_CLOSED 2'h3
`define DRSP_SITE_LINKED 2'h0
`define DRSP_SITE_REMOTE 2'h1
`define DRSP_SITE_LOCAL 2'h2
`define DRSP_ACT_NORMAL 1'h0
`define DRSP_ACT_INVERSE 1'h1
`define DRSP_FB_AIN54 2'h0
`define DRSP_FB_AIN53 2'h1
`define DRSP_FB_BUS 2'h2
`define DRSP_FB_AUX 2'h3
`define DRSP_TI_OFF 14'h2710
`define DRSP_LOCAL_RST 16'h0000
`define DRSP_RAMP_STEP 16'h0010
`define DRSP_PID_PERIOD_US 1000
`define DRSP_CLK_MHZ 50
`define DRSP_PID_CYCLES (`DRSP_PID_PERIOD_US * `DRSP_CLK_MHZ)
`define DRSP_LREF_STEP 16'h0001
`endif

/* File: rtl/drsp_tick.v */
// Divider giving one-cycle enable pulses for the controller update
`timescale 1ns/1ps
module drsp_tick #(
	parameter PERIOD = 50000
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Pulse out
	output reg tick
);
	reg [31:0] cnt_q;
	always @(posedge clk) begin
		if (reset) begin
			cnt_q <= 32'h00000000;
			tick <= 1'b0;
		end else if (cnt_q >= PERIOD - 1) begin
			cnt_q <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
			tick <= 1'b0;
		end
	end
endmodule

/* File: testbench/drsp_sensor.sv */
// Process feedback sensor model for the primary feedback input
`timescale 1ns/1ps
module drsp_sensor (
	// Clock
	input wire clk,
	// Process level set by the bench
	input wire [15:0] level,
	// Sensor reading
	output reg [15:0] reading
);
	// One-cycle lag, like a sampled transducer
	always @(posedge clk) begin
		reading <= level;
	end
endmodule

/* File: testbench/drsp_core_checker.sv */
// Port assertions for the reference select and process controller
`timescale 1ns/1ps
module drsp_core_checker (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Keys and remote command
	input wire key_hand,
	input wire key_off,
	input wire key_auto,
	input wire key_reset,
	input wire en_hand,
	input wire en_off,
	input wire en_auto,
	input wire en_reset,
	input wire remote_start,
	// Configuration
	input wire [1:0] ref_site,
	input wire [15:0] freq_max,
	// Status
	input wire hand_mode,
	input wire running,
	input wire alarm_clear,
	input wire local_active,
	input wire [15:0] motor_cmd
);
	wire hand_go = key_hand && en_hand;
	wire auto_go = key_auto && en_auto && !hand_go;
	wire off_go = key_off && en_off && !hand_go && !auto_go;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_hand;
		hand_go;
	endsequence
	sequence s_auto;
		auto_go;
	endsequence
	a_hand_key: assert property (s_hand |=> hand_mode && running)
		else $error("hand key not taken");
	a_auto_key: assert property (s_auto |=> !hand_mode && running == $past(running))
		else $error("auto key not taken");
	a_mode_held: assert property (!hand_go && !auto_go |=> $stable(hand_mode))
		else $error("mode moved without key");
	a_off_stops: assert property (off_go && !remote_start |=> !running)
		else $error("off key did not stop");
	a_alarm_cause: assert property (alarm_clear |-> $past(key_reset && en_reset))
		else $error("alarm clear without key");
	a_freq_clamp: assert property (motor_cmd <= freq_max)
		else $error("output above frequency limit");
	a_site_local: assert property (ref_site == 2'h2 |-> local_active)
		else $error("local site not local");
	a_site_remote: assert property (ref_site == 2'h1 |-> !local_active)
		else $error("remote site not remote");
	a_site_linked: assert property (ref_site == 2'h0 |-> local_active == hand_mode)
		else $error("linked site wrong");
endmodule
bind drsp_core drsp_core_checker chk (.clk, .reset, .key_hand, .key_off, .key_auto,
	.key_reset, .en_hand, .en_off, .en_auto, .en_reset, .remote_start, .ref_site,
	.freq_max, .hand_mode, .running, .alarm_clear, .local_active, .motor_cmd);

/* File: testbench/drsp_core_tb.sv */
// Self-checking bench for the reference select and process controller
`timescale 1ns/1ps
`include "drsp_map.vh"
module drsp_core_tb;
	localparam SMIN = 16'h0020;
	localparam FMAX = 16'h0600;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg load = 1'b0;
	reg inv = 1'b0;
	reg h = 1'b0;
	reg [5:0] key = 6'h00;
	reg [3:0] en = 4'hf;
	reg [1:0] rcmd = 2'h0;
	reg [1:0] mode = 2'h0;
	reg [1:0] site = 2'h0;
	reg [1:0] fsel = 2'h0;
	reg [13:0] ti = 14'h0001;
	reg [15:0] rref = 16'h0000;
	reg [15:0] sref = 16'h0500;
	reg [15:0] lvl = 16'h0000;
	reg [15:0] aux = 16'h0000;
	wire hm, run, la;
	wire [15:0] lref, mcmd, fb;
	integer mismatches = 0;
	integer compares = 0;
	integer seed = 32'hedd8;
	integer i, n;
	drsp_core #(.PID_CYCLES(4)) dut (.clk(clk), .reset(reset),
		.key_hand(key[0]), .key_off(key[1]), .key_auto(key[2]), .key_reset(key[3]),
		.key_up(key[4]), .key_down(key[5]), .en_hand(en[0]), .en_off(en[1]),
		.en_auto(en[2]), .en_reset(en[3]), .remote_start(rcmd[0]), .remote_stop(rcmd[1]),
		.remote_ref(rref), .local_ref_saved(sref), .local_ref_load(load), .cfg_mode(mode),
		.ref_site(site), .pid_inverse(inv), .pid_kp(16'h0100), .pid_ti(ti), .fb_select(fsel),
		.speed_min(SMIN), .speed_max(16'h0800), .freq_max(FMAX), .ramp_step(16'h0040),
		.fb_ain54(fb), .fb_ain53(aux), .fb_bus(lvl), .fb_aux(aux), .hand_mode(hm),
		.running(run), .alarm_clear(), .local_active(la), .local_ref(lref), .motor_cmd(mcmd));
	drsp_sensor sensor (.clk(clk), .level(lvl), .reading(fb));
	initial begin
		forever #10 clk = ~clk;
	end
	function exp_local(input [1:0] s, input hand);
		exp_local = (s == 2'h2) || (s == 2'h0 && hand);
	endfunction
	task check(input [15:0] got, input [15:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d mismatches %0d", compares, mismatches);
			if (mismatches == 0 && compares > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// Bounded wait; running out shows up as a mismatch
	task settle(input [15:0] exp);
		begin
			@(negedge clk);
			for (i = 0; i < 2000 && mcmd !== exp; i = i + 1)
				@(negedge clk);
			check(mcmd, exp);
			if (i == 2000)
				finish_test;
		end
	endtask
	task pulse(input [5:0] k, input ld);
		begin
			@(posedge clk);
			key <= k;
			load <= ld;
			@(posedge clk);
			key <= 6'h00;
			load <= 1'b0;
			@(negedge clk);
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		pulse(6'h00, 1'b1);
		check(lref, 16'h0500);
		pulse(6'h01, 1'b0);
		check({15'h0000, hm}, 16'h0001);
		h = 1'b1;
		settle(16'h0500);
		pulse(6'h10, 1'b0);
		check(lref, 16'h0500 + `DRSP_LREF_STEP);
		for (n = 0; n < 300; n = n + 1) begin
			@(posedge clk);
			key <= $random(seed);
			en <= $random(seed);
			rcmd <= $random(seed);
			fsel <= $random(seed);
			aux <= $random(seed);
			site <= {$random(seed)} % 3;
			@(negedge clk);
			check({15'h0000, la}, {15'h0000, exp_local(site, h)});
			check({15'h0000, hm}, {15'h0000, h});
			if (key[0] & en[0])
				h = 1'b1;
			else if (key[2] & en[2])
				h = 1'b0;
		end
		@(posedge clk);
		key <= 6'h00;
		en <= 4'hf;
		// Remote start held so auto mode keeps running
		rcmd <= 2'h1;
		fsel <= `DRSP_FB_AIN54;
		site <= `DRSP_SITE_REMOTE;
		mode <= `DRSP_CFG_CLOSED;
		rref <= 16'h0300;
		pulse(6'h04, 1'b0);
		// Feedback above or below setpoint must push speed the way the action says
		for (n = 0; n < 4; n = n + 1) begin
			@(posedge clk);
			inv <= n[1];
			lvl <= (n[0] ^ n[1]) ? 16'hffff : 16'h0000;
			settle(n[0] ? SMIN : FMAX);
		end
		// Auxiliary input selected while the default input reads high
		@(posedge clk);
		inv <= 1'b0;
		lvl <= 16'hffff;
		aux <= 16'h0000;
		fsel <= `DRSP_FB_AUX;
		settle(FMAX);
		@(posedge clk);
		aux <= 16'hffff;
		settle(SMIN);
		@(posedge clk);
		mode <= `DRSP_CFG_OPEN;
		rref <= 16'h0700;
		settle(FMAX);
		@(posedge clk);
		mode <= `DRSP_CFG_CLOSED;
		site <= `DRSP_SITE_LOCAL;
		sref <= 16'h0400;
		pulse(6'h00, 1'b1);
		settle(16'h0400);
		finish_test;
	end
endmodule
